/* hdl/dps_pkg.sv */
// Package: constants and types of the dual port register select block.
package dps_pkg;
    localparam logic [7:0] CRC_ERR_OFS    = 8'h1b;
    localparam logic [7:0] PIN_STS_LO_OFS = 8'h1c;
    localparam logic [7:0] PIN_STS_HI_OFS = 8'h1d;
    localparam logic [7:0] PORT_SEL_OFS   = 8'h1e;
    localparam logic [7:0] FREQ_CNT_OFS   = 8'h1f;

    localparam logic [7:0] PORT_SEL_RST   = 8'h01;
    localparam logic [7:0] ZERO8          = 8'h00;
    localparam logic [7:0] CNT_MAX        = 8'hff;
    localparam logic [6:0] ADDR_STEP      = 7'h01;

    localparam int FIRST_SEL_BIT  = 0;
    localparam int SECOND_SEL_BIT = 1;
    localparam int SECOND_EN_BIT  = 2;
    localparam int PORT_SEL_W     = 3;

    localparam int HI_PIN_LSB     = 5;
    localparam int LO_PIN_W       = 4;
    localparam int SYNC_STAGES    = 3;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [6:0] dev_addr;
        logic [7:0] reg_addr;
        logic [7:0] wdata;
    } dps_req_t;

    typedef struct packed {
        logic       ack;
        logic       nak;
        logic [7:0] rdata;
    } dps_rsp_t;

    typedef struct packed {
        logic [3:0] first_low;
        logic [2:0] first_high;
        logic [3:0] second_low;
        logic       pin8;
    } dps_pins_t;

    typedef enum logic [0:0] {
        FC_IDLE,
        FC_COUNT
    } dps_fc_state_t;
endpackage

/* hdl/dps_top.sv */
// Register access steering, pin status and error counters of the serializer.
`timescale 1ns/1ps
module dps_top (
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic [6:0]        primary_target_address,
    input  wire dps_pkg::dps_req_t req,
    output dps_pkg::dps_rsp_t      rsp_q,
    input  wire logic              bist_active,
    input  wire logic              bist_restart,
    input  wire logic              crc_error_clear,
    input  wire logic [1:0]        link_lost,
    input  wire logic [1:0]        backchannel_crc_error,
    input  wire dps_pkg::dps_pins_t pins,
    input  wire logic              pixel_clock,
    output logic [2:0]             port_select_q,
    output logic [1:0]             port_write_enable_q
);

    // Synchroniser chains: stage 0 feeds only stage 1.
    localparam int PIN_W = $bits(dps_pkg::dps_pins_t) + 1;
    logic [PIN_W-1:0] sync0_q;
    logic [PIN_W-1:0] sync1_q;
    logic [PIN_W-1:0] sync2_q;
    logic [PIN_W-1:0] stable_q;
    dps_pkg::dps_pins_t pin_lvl;
    logic              pclk_lvl;
    logic              pclk_prev_q;

    logic [7:0] tally_q [2];
    logic [7:0] tally_d [2];
    logic [7:0] edge_cnt_q;
    logic [7:0] window_q;
    dps_pkg::dps_fc_state_t fc_state_q;

    logic       hit_primary;
    logic       hit_second;
    logic       view_port1;
    logic [7:0] rdata;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sync0_q  <= '0;
            sync1_q  <= '0;
            sync2_q  <= '0;
            stable_q <= '0;
        end else begin
            sync0_q <= {pixel_clock, pins};
            sync1_q <= sync0_q;
            sync2_q <= sync1_q;
            // A level counts only once the last two stages agree.
            for (int i = 0; i < PIN_W; i++) begin
                if (sync1_q[i] == sync2_q[i]) begin
                    stable_q[i] <= sync2_q[i];
                end
            end
        end
    end

    assign pin_lvl  = stable_q[PIN_W-2:0];
    assign pclk_lvl = stable_q[PIN_W-1];

    assign hit_second = req.valid && port_select_q[dps_pkg::SECOND_EN_BIT]
        && (req.dev_addr == primary_target_address + dps_pkg::ADDR_STEP);
    assign hit_primary = req.valid
        && (req.dev_addr == primary_target_address);

    // Port view for this access. second address is port 1.
    // enable overrides bit 1. enable overrides bit 0.
    // bit 1 picks port 1. bit 1 beats bit 0 on reads.
    // otherwise port 0 copies are used.
    always_comb begin
        if (hit_second) begin
            view_port1 = 1'b1;
        end else if (port_select_q[dps_pkg::SECOND_EN_BIT]) begin
            view_port1 = 1'b0;
        end else begin
            view_port1 = port_select_q[dps_pkg::SECOND_SEL_BIT];
        end
    end

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            tally_d[p] = tally_q[p];
            if (bist_active && backchannel_crc_error[p]
                && tally_q[p] != dps_pkg::CNT_MAX) begin
                tally_d[p] = tally_q[p] + 8'h01;
            end
            if (link_lost[p] || bist_restart || crc_error_clear) begin
                tally_d[p] = dps_pkg::ZERO8;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tally_q[0] <= dps_pkg::ZERO8;
            tally_q[1] <= dps_pkg::ZERO8;
        end else begin
            tally_q[0] <= tally_d[0];
            tally_q[1] <= tally_d[1];
        end
    end

    // Read multiplexer; unlisted bits stay zero.
    always_comb begin
        rdata = dps_pkg::ZERO8;
        case (req.reg_addr)
            dps_pkg::CRC_ERR_OFS: begin
                rdata = view_port1 ? tally_q[1] : tally_q[0];
            end
            dps_pkg::PIN_STS_LO_OFS: begin
                // high pins zero on port 1
                if (!view_port1) begin
                    rdata[7:dps_pkg::HI_PIN_LSB] = pin_lvl.first_high;
                end
                rdata[dps_pkg::LO_PIN_W-1:0] = view_port1
                    ? pin_lvl.second_low : pin_lvl.first_low;
            end
            dps_pkg::PIN_STS_HI_OFS: begin
                rdata[0] = pin_lvl.pin8;
            end
            dps_pkg::PORT_SEL_OFS: begin
                rdata[dps_pkg::PORT_SEL_W-1:0] = port_select_q;
            end
            dps_pkg::FREQ_CNT_OFS: begin
                rdata = edge_cnt_q;
            end
            default: begin
                rdata = dps_pkg::ZERO8;
            end
        endcase
    end

    // Answer one cycle after the request; unmatched addresses are refused.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.ack   <= hit_primary || hit_second;
            rsp_q.nak   <= req.valid && !(hit_primary || hit_second);
            rsp_q.rdata <= (hit_primary || hit_second) ? rdata
                                                       : dps_pkg::ZERO8;
        end
    end

    // Write steering to port copies elsewhere in the device, one cycle late.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            port_write_enable_q <= 2'h0;
        end else if ((hit_primary || hit_second) && req.write) begin
            if (hit_second || (!port_select_q[dps_pkg::SECOND_EN_BIT]
                && port_select_q[dps_pkg::SECOND_SEL_BIT])) begin
                port_write_enable_q <= 2'h2;
            end else begin
                port_write_enable_q <= 2'h1;
            end
        end else begin
            port_write_enable_q <= 2'h0;
        end
    end

    // The select register is shared, so both addresses reach it.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            port_select_q <= dps_pkg::PORT_SEL_RST[dps_pkg::PORT_SEL_W-1:0];
        end else if ((hit_primary || hit_second) && req.write
                     && req.reg_addr == dps_pkg::PORT_SEL_OFS) begin
            port_select_q <= req.wdata[dps_pkg::PORT_SEL_W-1:0];
        end
    end

    // gated pixel edge count. Only rising edges are counted, and
    // the three-stage sampling with its two-stage agreement check limits pixel rates to a quarter of clk.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fc_state_q  <= dps_pkg::FC_IDLE;
            window_q    <= dps_pkg::ZERO8;
            edge_cnt_q  <= dps_pkg::ZERO8;
            pclk_prev_q <= 1'b0;
        end else begin
            pclk_prev_q <= pclk_lvl;
            if ((hit_primary || hit_second) && req.write
                && req.reg_addr == dps_pkg::FREQ_CNT_OFS) begin
                window_q   <= req.wdata;
                edge_cnt_q <= dps_pkg::ZERO8;
                fc_state_q <= (req.wdata == dps_pkg::ZERO8)
                    ? dps_pkg::FC_IDLE : dps_pkg::FC_COUNT;
            end else begin
                case (fc_state_q)
                    dps_pkg::FC_COUNT: begin
                        if (pclk_lvl && !pclk_prev_q
                            && edge_cnt_q != dps_pkg::CNT_MAX) begin
                            edge_cnt_q <= edge_cnt_q + 8'h01;
                        end
                        window_q <= window_q - 8'h01;
                        if (window_q == 8'h01) begin
                            fc_state_q <= dps_pkg::FC_IDLE;
                        end
                    end
                    default: begin
                        fc_state_q <= dps_pkg::FC_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // dps_top

/* dv/dps_top_sva.sv */
// Port assertions of the register select block.
`timescale 1ns/1ps
module dps_top_sva (
    input wire logic              clk_sys,
    input wire logic              sys_rst,
    input wire logic [6:0]        primary_target_address,
    input wire dps_pkg::dps_req_t req,
    input wire dps_pkg::dps_rsp_t rsp_q,
    input wire logic [2:0]        port_select_q,
    input wire logic [1:0]        port_write_enable_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic       pri, sec, rd, wr;
    logic [2:0] ws;
    logic [7:0] ra;
    assign ra  = req.reg_addr;
    assign ws  = req.wdata[2:0];
    assign pri = req.valid && req.dev_addr == primary_target_address;
    assign sec = req.valid && !pri &&
                 req.dev_addr == primary_target_address + 7'h01;
    assign rd  = (pri || sec) && !req.write;
    assign wr  = pri && req.write;
    a_primary_ack: assert property (pri |=> rsp_q.ack && !rsp_q.nak)
        else $error("primary access not acknowledged");
    a_second_ack: assert property (sec && port_select_q[2] |=> rsp_q.ack)
        else $error("second address not acknowledged");
    a_second_off: assert property (sec && !port_select_q[2] |=>
        rsp_q.nak && port_write_enable_q == 2'h0)
        else $error("second address answered while disabled");
    a_status_high: assert property (rd && ra == 8'h1d |=>
        rsp_q.rdata[7:1] == 7'h00) else $error("pin status high bits set");
    a_status_gap: assert property (rd && ra == 8'h1c |=>
        !rsp_q.rdata[4]) else $error("reserved status bit set");
    a_port1_pins: assert property ((sec || pri &&
        port_select_q[2:1] == 2'h1) && rd && ra == 8'h1c |=>
        rsp_q.rdata[7:5] == 3'h0) else $error("port one pins not zero");
    a_select_store: assert property (wr && ra == 8'h1e |=>
        port_select_q == $past(ws)) else $error("select not stored");
    a_port1_write: assert property (wr && port_select_q[2:1] == 2'h1 |=>
        port_write_enable_q == 2'h2) else $error("port one not written");
    a_port0_write: assert property (wr && port_select_q[2:1] != 2'h1 |=>
        port_write_enable_q == 2'h1) else $error("port zero not written");
    cover property (sec && port_select_q[2]);
    cover property (wr && port_select_q[1]);
    cover property (rsp_q.nak);
endmodule // dps_top_sva

/* dv/dps_host_model.sv */
// Register host that issues one single-byte access at a time.
`timescale 1ns/1ps
module dps_host_model (
    input  wire logic              clk_sys,
    output dps_pkg::dps_req_t      req,
    input  wire dps_pkg::dps_rsp_t rsp_q
);
    initial req = '0;
    // The bench first reads at the reset select, then writes each select before the reads that use it.
    task automatic xfer(input logic wr, input logic [6:0] dev,
        input logic [7:0] ra, input logic [7:0] wd,
        output logic [1:0] an, output logic [7:0] rd);
        @(negedge clk_sys);
        req = '{1'b1, wr, dev, ra, wd};
        @(negedge clk_sys);
        // The answer stands for one cycle only, so it is taken here.
        an = {rsp_q.ack, rsp_q.nak};
        rd = rsp_q.rdata;
        // Released fields turn over so a stale value is never trusted.
        req = '{1'b0, ~wr, ~dev, ~ra, ~wd};
    endtask
endmodule // dps_host_model

/* dv/dps_top_test.sv */
// Self-checking bench for the register select block.
`timescale 1ns/1ps
module dps_top_test;
    logic [6:0]  primary_target_address = 7'h2a;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        bist_active = 1'b0;
    logic        bist_restart = 1'b0;
    logic        crc_error_clear = 1'b0;
    logic [1:0]  link_lost = 2'h0;
    logic [1:0]  backchannel_crc_error = 2'h0;
    logic        pixel_clock = 1'b0;
    logic        pix_on = 1'b0;
    logic [1:0]  an;
    logic [7:0]  rd;
    logic [39:0] r;
    int          errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    dps_pkg::dps_pins_t pins = '{4'ha, 3'h5, 4'h5, 1'b1};
    dps_pkg::dps_req_t  req;
    dps_pkg::dps_rsp_t  rsp_q;
    logic [2:0]  port_select_q;
    logic [1:0]  port_write_enable_q;
    // Flags, register, write data, answer, read data.
    logic [39:0] rows [17] = '{
        40'h00_1e_00_02_01, 40'h00_1c_00_02_aa,
        40'h00_1d_00_02_01, 40'h01_1c_00_01_00,
        40'h10_1e_ff_02_00, 40'h00_1e_00_02_07,
        40'h00_1c_00_02_aa, 40'h01_1c_00_02_05,
        40'h10_1e_02_02_00, 40'h00_1c_00_02_05,
        40'h10_1e_03_02_00, 40'h00_1c_00_02_05,
        40'h10_1e_00_02_00, 40'h00_1c_00_02_aa,
        40'h10_40_5a_02_00, 40'h00_40_00_02_00,
        40'h10_1e_01_02_00};
    dps_top dps_top_inst (.clk_sys, .sys_rst, .primary_target_address,
        .req, .rsp_q, .bist_active, .bist_restart, .crc_error_clear,
        .link_lost, .backchannel_crc_error, .pins, .pixel_clock,
        .port_select_q, .port_write_enable_q);
    dps_host_model host_inst (.clk_sys, .req, .rsp_q);
    always #2.5 clk_sys = ~clk_sys;
    // The pixel clock stands still while pix_on is low.
    always #10 pixel_clock = pix_on ? ~pixel_clock : 1'b0;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            final_report();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic s, input logic [7:0] a,
        input logic [7:0] d);
        host_inst.xfer(w, primary_target_address + {6'h0, s}, a, d, an, rd);
    endtask
    task automatic pulse(input logic [1:0] p, input int n);
        repeat (n) begin
            @(negedge clk_sys);
            backchannel_crc_error = p;
            @(negedge clk_sys);
            backchannel_crc_error = 2'h0;
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        for (int i = 0; i < 17; i++) begin
            r = rows[i];
            acc(r[36], r[32], r[31:24], r[23:16]);
            check({6'h0, an}, r[15:8]);
            if (!r[36]) check(rd, r[7:0]);
        end
        pulse(2'h1, 2);
        bist_active = 1'b1;
        pulse(2'h1, 3);
        pulse(2'h2, 5);
        acc(0, 0, 8'h1b, 8'h00);
        check(rd, 8'h03);
        acc(1, 0, 8'h1e, 8'h02);
        check({6'h0, port_write_enable_q}, 8'h01);
        acc(0, 0, 8'h1b, 8'h00);
        check(rd, 8'h05);
        link_lost = 2'h2;
        acc(0, 0, 8'h1b, 8'h00);
        check(rd, 8'h00);
        link_lost = 2'h0;
        acc(1, 0, 8'h1e, 8'h01);
        pulse(2'h1, 2);
        bist_restart = 1'b1;
        acc(0, 0, 8'h1b, 8'h00);
        check(rd, 8'h00);
        bist_restart = 1'b0;
        pulse(2'h1, 1);
        crc_error_clear = 1'b1;
        acc(0, 0, 8'h1b, 8'h00);
        check(rd, 8'h00);
        pix_on = 1'b1;
        acc(1, 0, 8'h1f, 8'h28);
        repeat (50) @(negedge clk_sys);
        pix_on = 1'b0;
        acc(0, 0, 8'h1f, 8'h00);
        check({7'h0, rd >= 8'h09 && rd <= 8'h0b}, 8'h01);
        // A reset in mid-run must drop the select and the edge count.
        acc(1, 0, 8'h1e, 8'h06);
        sys_rst = 1'b1;
        @(negedge clk_sys);
        check({5'h0, port_select_q}, 8'h01);
        check({6'h0, port_write_enable_q}, 8'h00);
        sys_rst = 1'b0;
        acc(0, 0, 8'h1f, 8'h00);
        check(rd, 8'h00);
        final_report();
    end
endmodule // dps_top_test
bind dps_top dps_top_sva dps_top_sva_inst (.clk_sys, .sys_rst,
    .primary_target_address, .req, .rsp_q, .port_select_q,
    .port_write_enable_q);
